// [tws_defines.vh]
// Constants for the two-wire slave receiver: offsets, fields, codes and reset values
`ifndef TWS_DEFINES_VH
`define TWS_DEFINES_VH

// Register offsets on the plain register port
`define TWS_OFS_OWN_ADDR  2'h0
`define TWS_OFS_CONTROL   2'h1
`define TWS_OFS_STATUS    2'h2
`define TWS_OFS_DATA      2'h3

// Control register fields
`define TWS_CTL_STEP_DONE  7
`define TWS_CTL_ACK_EN     6
`define TWS_CTL_START      5
`define TWS_CTL_STOP       4
`define TWS_CTL_WCOL       3
`define TWS_CTL_ENABLE     2
`define TWS_CTL_INT_EN     0

// Own address register fields
`define TWS_OAR_GC_EN      0
`define TWS_OAR_ADDR_MSB   7
`define TWS_OAR_ADDR_LSB   1

// Reset values
`define TWS_RST_OWN_ADDR   8'h00
`define TWS_RST_CONTROL    8'h00
`define TWS_RST_DATA       8'hFF

// General call address
`define TWS_GC_ADDR        7'h00

// Status codes, prescaler bits zero
`define TWS_SC_OWN_W       8'h60
`define TWS_SC_ARB_OWN_W   8'h68
`define TWS_SC_GC          8'h70
`define TWS_SC_ARB_GC      8'h78
`define TWS_SC_OWN_ACK     8'h80
`define TWS_SC_OWN_NACK    8'h88
`define TWS_SC_GC_ACK      8'h90
`define TWS_SC_GC_NACK     8'h98
`define TWS_SC_STOP        8'hA0
`define TWS_SC_IDLE        8'hF8

// Bits per byte on the bus
`define TWS_BYTE_BITS      4'h8

`endif

// [tws_slave_rx.v]
// Two-wire slave receiver: register port, bus sampling and byte reception
// Summary of operation
// - Answer a bus address equal to the own-address register upper seven bits.
// - With general call enable set, also answer address 0x00; else ignore it.
// - After address match, write bit enters receive; read bit is not acked and the frame is skipped.
// - After own address plus write, set the step flag with a valid status.
// - Lost arbitration then addressed still enters receive, codes 0x68 and 0x78.
// - Ack enable cleared mid-transfer gives NACK after the next data byte.
// - Ack enable zero: own address not acknowledged, bus still watched.
// - In sleep other than idle the interface system clock is stopped.
// - In sleep with ack enable, address still recognised and acked, then wake.
// - After wake, SCL held low until software writes one to the step flag.
// - After sleep wake, data register need not hold the last bus byte.
// - 0x60: own address and write acked; next byte acked per ack enable.
// - 0x68: arbitration lost, own address and write acked; next byte per ack.
// - 0x70: general call acked; next byte acked per ack enable.
// - 0x78: arbitration lost, general call acked; next byte per ack enable.
// - 0x80: data byte received and acked; software reads it and clears flag.
// - 0x88: byte received, NACK returned; go to not-addressed slave state.
// - Not addressed with ack enable: recognise addresses; start request when bus free.
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ns
`include "tws_defines.vh"

module tws_slave_rx
(
  input  wire       sys_clk,
  input  wire       nrst,
  input  wire [1:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       scl_in,
  output reg        scl_out,
  output reg        scl_oe,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe,
  input  wire       arb_lost,
  input  wire       sleep_mode,
  output reg        wake_up,
  output reg        clk_stop,
  output reg        start_issue
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_RECV = 3'h1;
  localparam [2:0] S_ACK  = 3'h2;
  localparam [2:0] S_HOLD = 3'h3;
  localparam [2:0] S_SKIP = 3'h4;

  // Address decode for the write path; the read path uses a case on reg_addr
  function sel;
    input [1:0] a;
    input [1:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  reg [7:0] own_addr_reg;
  reg [7:0] status_reg;
  reg [7:0] data_reg;
  reg       flag_reg;
  reg       ack_en_reg;
  reg       start_req_reg;
  reg       stop_req_reg;
  reg       wcol_reg;
  reg       enable_reg;
  reg       int_en_reg;
  reg [2:0] state_reg;
  reg [7:0] shift_reg;
  reg [3:0] bit_cnt_reg;
  reg       addr_phase_reg;
  reg       gc_sel_reg;
  reg       arb_reg;
  reg       do_ack_reg;
  reg       to_idle_reg;
  reg       busy_reg;
  reg       start_done_reg;
  reg [1:0] scl_sync_reg;
  reg [1:0] sda_sync_reg;
  reg       scl_prev_reg;
  reg       sda_prev_reg;

  wire scl_s = scl_sync_reg[1];
  wire sda_s = sda_sync_reg[1];
  wire scl_rise = scl_s & ~scl_prev_reg;
  wire scl_fall = ~scl_s & scl_prev_reg;
  wire bus_start = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  wire bus_stop = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

  wire wr_ctl = reg_wr & sel(reg_addr, `TWS_OFS_CONTROL);
  wire wr_dat = reg_wr & sel(reg_addr, `TWS_OFS_DATA);
  wire flag_clr = wr_ctl & reg_wdata[`TWS_CTL_STEP_DONE];

  wire own_hit = (shift_reg[7:1] == own_addr_reg[`TWS_OAR_ADDR_MSB:`TWS_OAR_ADDR_LSB]);
  wire gc_hit = own_addr_reg[`TWS_OAR_GC_EN] & (shift_reg[7:1] == `TWS_GC_ADDR);
  // Read direction belongs to the transmitter, which this block leaves out
  wire addr_ok = ack_en_reg & (own_hit | gc_hit) & ~shift_reg[0];
  wire byte_done = (bit_cnt_reg == `TWS_BYTE_BITS);

  // Event that sets the step flag this cycle
  reg       flag_set;
  reg [7:0] status_next;
  always @*
  begin
    flag_set = 1'b0;
    status_next = status_reg;
    if (enable_reg && state_reg == S_ACK && scl_fall && do_ack_reg && addr_phase_reg)
    begin
      flag_set = 1'b1;
      if (gc_sel_reg)
        status_next = arb_reg ? `TWS_SC_ARB_GC : `TWS_SC_GC;
      else
        status_next = arb_reg ? `TWS_SC_ARB_OWN_W : `TWS_SC_OWN_W;
    end
    else if (enable_reg && state_reg == S_ACK && scl_fall && !addr_phase_reg)
    begin
      flag_set = 1'b1;
      if (gc_sel_reg)
        status_next = do_ack_reg ? `TWS_SC_GC_ACK : `TWS_SC_GC_NACK;
      else
        status_next = do_ack_reg ? `TWS_SC_OWN_ACK : `TWS_SC_OWN_NACK;
    end
    else if (enable_reg && (bus_start || bus_stop) && state_reg != S_IDLE
             && state_reg != S_SKIP && !addr_phase_reg)
    begin
      flag_set = 1'b1;
      status_next = `TWS_SC_STOP;
    end
    else if (flag_clr)
      status_next = `TWS_SC_IDLE;
  end

  // Pin synchronisers; the first stage feeds only the second
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  // Software-visible registers
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      own_addr_reg <= `TWS_RST_OWN_ADDR;
      ack_en_reg <= 1'b0;
      start_req_reg <= 1'b0;
      stop_req_reg <= 1'b0;
      enable_reg <= 1'b0;
      int_en_reg <= 1'b0;
      flag_reg <= 1'b0;
      wcol_reg <= 1'b0;
      status_reg <= `TWS_SC_IDLE;
      reg_rdata <= 8'h00;
    end
    else
    begin
      if (reg_wr && sel(reg_addr, `TWS_OFS_OWN_ADDR))
        own_addr_reg <= reg_wdata;
      if (wr_ctl)
      begin
        ack_en_reg <= reg_wdata[`TWS_CTL_ACK_EN];
        start_req_reg <= reg_wdata[`TWS_CTL_START];
        stop_req_reg <= reg_wdata[`TWS_CTL_STOP];
        enable_reg <= reg_wdata[`TWS_CTL_ENABLE];
        int_en_reg <= reg_wdata[`TWS_CTL_INT_EN];
      end
      // A hardware set in the same cycle as a software clear wins
      if (flag_set)
        flag_reg <= 1'b1;
      else if (flag_clr)
        flag_reg <= 1'b0;
      if (wr_dat && !flag_reg)
        wcol_reg <= 1'b1;
      else if (wr_dat)
        wcol_reg <= 1'b0;
      status_reg <= status_next;
      reg_rdata <= 8'h00;
      if (reg_rd)
      begin
        case (reg_addr)
          `TWS_OFS_OWN_ADDR: reg_rdata <= own_addr_reg;
          `TWS_OFS_CONTROL:  reg_rdata <= {flag_reg, ack_en_reg, start_req_reg, stop_req_reg,
                                           wcol_reg, enable_reg, 1'b0, int_en_reg};
          // Prescaler bits always read zero here, so codes need no masking
          `TWS_OFS_STATUS:   reg_rdata <= status_reg;
          default:           reg_rdata <= data_reg;
        endcase
      end
    end
  end

  // Bus-facing receiver
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= S_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      addr_phase_reg <= 1'b1;
      gc_sel_reg <= 1'b0;
      arb_reg <= 1'b0;
      do_ack_reg <= 1'b0;
      to_idle_reg <= 1'b0;
      busy_reg <= 1'b0;
      start_done_reg <= 1'b0;
      data_reg <= `TWS_RST_DATA;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      wake_up <= 1'b0;
      clk_stop <= 1'b0;
      start_issue <= 1'b0;
    end
    else
    begin
      wake_up <= 1'b0;
      start_issue <= 1'b0;
      if (arb_lost)
        arb_reg <= 1'b1;
      if (bus_start)
        busy_reg <= 1'b1;
      else if (bus_stop)
        busy_reg <= 1'b0;
      if (wr_dat && flag_reg)
        data_reg <= reg_wdata;
      // Only the address-recognition path runs on the bus while stopped
      clk_stop <= sleep_mode && state_reg != S_HOLD && state_reg != S_ACK;
      if (!start_req_reg)
        start_done_reg <= 1'b0;
      if (!enable_reg)
      begin
        state_reg <= S_IDLE;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
        addr_phase_reg <= 1'b1;
      end
      else if (bus_start)
      begin
        state_reg <= S_RECV;
        bit_cnt_reg <= 4'h0;
        addr_phase_reg <= 1'b1;
        sda_oe <= 1'b0;
        scl_oe <= 1'b0;
      end
      else if (bus_stop)
      begin
        state_reg <= S_IDLE;
        addr_phase_reg <= 1'b1;
        sda_oe <= 1'b0;
        scl_oe <= 1'b0;
      end
      else
      begin
        case (state_reg)
          S_IDLE:
          begin
            addr_phase_reg <= 1'b1;
            if (start_req_reg && !busy_reg && !start_done_reg)
            begin
              start_issue <= 1'b1;
              start_done_reg <= 1'b1;
            end
          end
          S_RECV:
          begin
            if (scl_rise && !byte_done)
            begin
              shift_reg <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            else if (scl_fall && byte_done)
            begin
              bit_cnt_reg <= 4'h0;
              if (addr_phase_reg)
              begin
                if (addr_ok)
                begin
                  sda_oe <= 1'b1;
                  do_ack_reg <= 1'b1;
                  gc_sel_reg <= ~own_hit;
                  state_reg <= S_ACK;
                  if (sleep_mode)
                    wake_up <= 1'b1;
                end
                else
                  state_reg <= S_SKIP;
              end
              else
              begin
                // Ack enable is sampled per byte, so clearing it NACKs the next byte
                sda_oe <= ack_en_reg;
                do_ack_reg <= ack_en_reg;
                // Bytes are only taken with clocks running, never during sleep
                if (!sleep_mode)
                  data_reg <= shift_reg;
                state_reg <= S_ACK;
              end
            end
          end
          S_ACK:
          begin
            if (scl_fall)
            begin
              sda_oe <= 1'b0;
              scl_oe <= 1'b1;
              to_idle_reg <= ~do_ack_reg;
              if (addr_phase_reg)
                arb_reg <= 1'b0;
              addr_phase_reg <= 1'b0;
              state_reg <= S_HOLD;
            end
          end
          S_HOLD:
          begin
            // Stretching can last as long as software takes, blocking the bus
            if (!flag_reg)
            begin
              scl_oe <= 1'b0;
              state_reg <= to_idle_reg ? S_IDLE : S_RECV;
              addr_phase_reg <= to_idle_reg;
            end
          end
          S_SKIP:
            addr_phase_reg <= 1'b1;
          default:
            state_reg <= S_IDLE;
        endcase
      end
    end
  end

endmodule // tws_slave_rx

// [tws_master_model.sv]
// Bus master model for the two-wire link
`timescale 1ns/1ns
module tws_master_model
(
  input  wire scl,
  input  wire sda,
  output reg  scl_m = 1'b1,
  output reg  sda_m = 1'b1
);
  // The 25 ns offset keeps bus edges clear of sys_clk edges
  task bit_x(input b, output s);
  begin
    sda_m = b;
    #200 scl_m = 1'b1;
    // The slave may stretch the clock low
    wait (scl === 1'b1);
    #300 s = sda;
    #100 scl_m = 1'b0;
    #200;
  end
  endtask
  task start;
  begin
    #25 sda_m = 1'b0;
    #400 scl_m = 1'b0;
    #200;
  end
  endtask
  task stop;
  begin
    #25 sda_m = 1'b0;
    #200 scl_m = 1'b1;
    wait (scl === 1'b1);
    #425 sda_m = 1'b1;
    #400;
  end
  endtask
  task send(input [7:0] d, output ack);
    integer i;
    reg     s;
  begin
    #25;
    for (i = 7; i >= 0; i = i - 1)
      bit_x(d[i], s);
    bit_x(1'b1, s);
    ack = !s;
  end
  endtask
endmodule // tws_master_model

// [tws_slave_rx_chk.sv]
// Port checker for the two-wire slave receiver
`timescale 1ns/1ns
module tws_slave_rx_chk
(
  input wire       sys_clk,
  input wire       nrst,
  input wire [1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       scl_in,
  input wire       scl_out,
  input wire       scl_oe,
  input wire       sda_in,
  input wire       sda_out,
  input wire       sda_oe,
  input wire       arb_lost,
  input wire       sleep_mode,
  input wire       wake_up,
  input wire       clk_stop,
  input wire       start_issue
);
  // Ack enable rebuilt from control writes
  reg  ack_sh;
  wire clr = reg_wr && reg_addr == 2'h1 && reg_wdata[7];
  always @(posedge sys_clk or negedge nrst)
    if (!nrst)
      ack_sh <= 1'b0;
    else if (reg_wr && reg_addr == 2'h1)
      ack_sh <= reg_wdata[6];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  status_code_a: assert property ($past(reg_rd && reg_addr == 2'h2) |-> reg_rdata[2:0] == 3'h0)
    else $error("status low bits set");
  ack_gate_a: assert property ($rose(sda_oe) |-> ack_sh)
    else $error("ack without ack enable");
  ack_phase_a: assert property ($rose(sda_oe) |-> !scl_in ##1 sda_oe [*4])
    else $error("ack not held");
  hold_low_a: assert property (scl_oe && !clr && !$past(clr) && !$past(clr, 2) |=> scl_oe)
    else $error("clock hold dropped");
  hold_end_a: assert property (clr && scl_oe |-> ##[1:3] !scl_oe)
    else $error("clock hold not released");
  wake_pulse_a: assert property (wake_up |-> $past(sleep_mode) ##1 !wake_up ##[0:30] scl_oe)
    else $error("bad wake pulse");
  clk_stop_a: assert property (clk_stop |-> $past(sleep_mode))
    else $error("clock stop while awake");
  start_pulse_a: assert property (start_issue |-> !scl_oe ##1 !start_issue)
    else $error("bad start pulse");
  open_drain_a: assert property (!scl_out && !sda_out)
    else $error("pin driven high");
endmodule // tws_slave_rx_chk
bind tws_slave_rx tws_slave_rx_chk u_chk (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .arb_lost(arb_lost), .sleep_mode(sleep_mode), .wake_up(wake_up),
  .clk_stop(clk_stop), .start_issue(start_issue));

// [tb_tws_slave_rx.sv]
// Self-checking bench for the two-wire slave receiver
`timescale 1ns/1ns
module tb_tws_slave_rx;
  localparam [7:0] ON = 8'h44, CLR = 8'hC4, CLR_NA = 8'h84;
  reg sys_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, arb_lost = 1'b0;
  reg sleep_mode = 1'b0, ack;
  reg  [1:0] reg_addr = 2'h0;
  reg  [7:0] reg_wdata = 8'h00;
  wire [7:0] reg_rdata;
  wire scl_out, scl_oe, sda_out, sda_oe, scl_m, sda_m, wake_up, clk_stop, start_issue;
  // Open-drain wires with pull-ups
  wire scl = scl_m & ~scl_oe;
  wire sda = sda_m & ~sda_oe;
  integer err_total = 0, n_compared = 0, n_wake = 0, n_start = 0;
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    n_wake = n_wake + (wake_up === 1'b1);
    n_start = n_start + (start_issue === 1'b1);
  end
  tws_slave_rx u_tws_slave_rx (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .arb_lost(arb_lost), .sleep_mode(sleep_mode), .wake_up(wake_up),
    .clk_stop(clk_stop), .start_issue(start_issue));
  tws_master_model u_tws_master_model (.scl(scl), .sda(sda), .scl_m(scl_m), .sda_m(sda_m));
  task check(input [63:0] what, input [7:0] seen, input [7:0] exp);
  begin
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  task wr(input [1:0] a, input [7:0] d);
  begin
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  end
  endtask
  task rd(input [1:0] a, input [7:0] exp);
  begin
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check({"reg", 6'h0C, a}, reg_rdata, exp);
  end
  endtask
  task xfer(input [7:0] b, input ea, input ef, input [7:0] st);
    integer i;
  begin
    u_tws_master_model.send(b, ack);
    for (i = 0; i < 10 && scl_oe !== 1'b1; i = i + 1)
      @(posedge sys_clk);
    check("ack", {7'h0, ack}, {7'h0, ea});
    check("stretch", {7'h0, scl_oe}, {7'h0, ef});
    if (ef)
      rd(2'h2, st);
  end
  endtask
  task frame_nak(input [7:0] b);
  begin
    u_tws_master_model.start;
    xfer(b, 1'b0, 1'b0, 8'h00);
    u_tws_master_model.stop;
  end
  endtask
  task stop_a0;
  begin
    wr(2'h1, CLR);
    u_tws_master_model.stop;
    repeat (6) @(posedge sys_clk);
    rd(2'h2, 8'hA0);
    wr(2'h1, CLR);
  end
  endtask
  task t_own;
  begin
    rd(2'h2, 8'hF8);
    rd(2'h3, 8'hFF);
    wr(2'h0, 8'h54);
    rd(2'h0, 8'h54);
    wr(2'h1, ON);
    // Data write with the flag low is refused and raises the collision bit
    wr(2'h3, 8'h12);
    rd(2'h1, 8'h4C);
    rd(2'h3, 8'hFF);
    u_tws_master_model.start;
    xfer(8'h54, 1'b1, 1'b1, 8'h60);
    wr(2'h1, CLR);
    repeat (3) @(posedge sys_clk);
    check("release", {7'h0, scl_oe}, 8'h00);
    xfer(8'hA5, 1'b1, 1'b1, 8'h80);
    rd(2'h3, 8'hA5);
    wr(2'h1, CLR_NA);
    xfer(8'h5A, 1'b0, 1'b1, 8'h88);
    wr(2'h1, CLR_NA);
    u_tws_master_model.stop;
    frame_nak(8'h54);
    wr(2'h1, ON);
    frame_nak(8'h56);
    frame_nak(8'h55);
    frame_nak(8'h00);
    $display("own address test done");
  end
  endtask
  task t_gc;
    integer i;
  begin
    wr(2'h0, 8'h55);
    u_tws_master_model.start;
    xfer(8'h00, 1'b1, 1'b1, 8'h70);
    wr(2'h1, CLR);
    xfer(8'h3C, 1'b1, 1'b1, 8'h90);
    stop_a0;
    for (i = 0; i < 2; i = i + 1)
    begin
      @(posedge sys_clk);
      arb_lost <= 1'b1;
      @(posedge sys_clk);
      arb_lost <= 1'b0;
      u_tws_master_model.start;
      xfer(i ? 8'h00 : 8'h54, 1'b1, 1'b1, i ? 8'h78 : 8'h68);
      wr(2'h1, CLR_NA);
      xfer(8'hC3, 1'b0, 1'b1, i ? 8'h98 : 8'h88);
      wr(2'h1, CLR);
      u_tws_master_model.stop;
    end
    $display("general call test done");
  end
  endtask
  task t_sleep;
  begin
    @(posedge sys_clk);
    sleep_mode <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check("clk_stop", {7'h0, clk_stop}, 8'h01);
    u_tws_master_model.start;
    xfer(8'h54, 1'b1, 1'b1, 8'h60);
    check("wake", n_wake[7:0], 8'h01);
    repeat (20) @(posedge sys_clk);
    check("hold", {7'h0, scl_oe}, 8'h01);
    sleep_mode <= 1'b0;
    wr(2'h1, CLR);
    xfer(8'h96, 1'b1, 1'b1, 8'h80);
    rd(2'h3, 8'h96);
    stop_a0;
    wr(2'h1, 8'h64);
    repeat (20) @(posedge sys_clk);
    check("start", n_start[7:0], 8'h01);
    wr(2'h1, ON);
    $display("sleep and start test done");
  end
  endtask
  task end_sim;
  begin
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  initial
  begin
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    t_own;
    t_gc;
    t_sleep;
    end_sim;
  end
  initial
  begin
    #3000000;
    err_total = err_total + 1;
    end_sim;
  end
endmodule // tb_tws_slave_rx
